// ===== udf_defines.vh
// Shared constants for the invalid-opcode and coprocessor-unavailable fault detector
`ifndef UDF_DEFINES_VH
`define UDF_DEFINES_VH

`define UDF_VEC_W          8
`define UDF_VEC_DIVIDE     8'h00
`define UDF_VEC_INV_OP     8'h06
`define UDF_VEC_COPROC_NA  8'h07
`define UDF_VEC_DBL_FAULT  8'h08
`define UDF_VEC_CONTRIB_LO 8'h0a
`define UDF_VEC_CONTRIB_HI 8'h0d
`define UDF_VEC_PAGE       8'h0e

`define UDF_CLS_W          2
`define UDF_CLS_BENIGN     2'h0
`define UDF_CLS_CONTRIB    2'h1
`define UDF_CLS_PAGE       2'h2

`define UDF_OPC_RSVD_A     8'hd6
`define UDF_OPC_RSVD_B     8'hf1

`define UDF_EXT_N          5
`define UDF_IP_W           32
`define UDF_ERR_W          32
`define UDF_ERR_ZERO       32'h0000_0000

`define UDF_ST_W           2
`define UDF_ST_IDLE        2'h0
`define UDF_ST_DELIVER     2'h1
`define UDF_ST_DBL         2'h2
`define UDF_ST_SHUTDOWN    2'h3

`endif

// ===== udf_classify.v
// Sorts an exception vector into benign, contributory or page-fault class
`timescale 1ns/1ps
`include "udf_defines.vh"
module udf_classify (
    input  wire [`UDF_VEC_W-1:0] i_vector,  // Exception vector
    output reg  [`UDF_CLS_W-1:0] o_class    // Class code
);
    always @* begin
        if (i_vector == `UDF_VEC_DIVIDE) begin
            o_class = `UDF_CLS_CONTRIB;
        end else if (i_vector >= `UDF_VEC_CONTRIB_LO && i_vector <= `UDF_VEC_CONTRIB_HI) begin
            o_class = `UDF_CLS_CONTRIB;
        end else if (i_vector == `UDF_VEC_PAGE) begin
            o_class = `UDF_CLS_PAGE;
        end else begin
            // Software and external interrupts land here too
            o_class = `UDF_CLS_BENIGN;
        end
    end
endmodule

// ===== udf_detect.v
// Retirement-time invalid-opcode and coprocessor-unavailable detector with double-fault sequencing
`timescale 1ns/1ps
`include "udf_defines.vh"
module udf_detect (
    input  wire                   i_ref_clk,                  // Core clock
    input  wire                   i_resetn,                   // Async reset, active low
    // Retiring instruction attributes from decode
    input  wire                   i_retire_valid,             // Instruction retiring this cycle
    input  wire [`UDF_IP_W-1:0]   i_retire_ip,                // Pointer of retiring instruction
    input  wire [7:0]             i_ins_opcode,               // Primary opcode byte
    input  wire                   i_ins_one_byte,             // Opcode is a single-byte form
    input  wire                   i_ins_reserved,             // Encoding invalid or reserved
    input  wire                   i_ins_bad_operand,          // Operand form illegal for opcode
    input  wire [`UDF_EXT_N-1:0]  i_ins_ext_req,              // Extensions this instruction needs
    input  wire [`UDF_EXT_N-1:0]  i_feature_id_query,         // Advertised extension flags
    input  wire                   i_ins_x87,                  // x87 floating-point instruction
    input  wire                   i_ins_pkint,                // Packed-integer instruction
    input  wire                   i_ins_simd,                 // Streaming SIMD instruction
    input  wire                   i_ins_trap_exempt,          // Fence, prefetch, pause, flush, nt store
    input  wire                   i_ins_mon_wait,             // Monitor or mwait
    input  wire                   i_ins_save_exempt,          // Exempt from SIMD state-save check
    input  wire                   i_ins_simd_fp_exc,          // SIMD FP exception produced
    input  wire                   i_ins_forced_undef,         // Forced-undefined instruction
    input  wire                   i_ins_lock,                 // Lock prefix present
    input  wire                   i_ins_lockable,             // Instruction may be locked
    input  wire                   i_ins_dest_mem,             // Destination is memory
    input  wire                   i_ins_sys_desc,             // Descriptor/verify/privilege-adjust op
    input  wire                   i_ins_resume_sysmgmt,       // Resume-from-system-management op
    input  wire                   i_ins_fpu_sync,             // FPU synchronise instruction
    input  wire                   i_ins_other_exc,            // Other fault found on this instruction
    input  wire [`UDF_VEC_W-1:0]  i_ins_other_vec,            // Vector of that other fault
    // Processor mode and control flags
    input  wire                   i_mode_real,                // Real-address mode
    input  wire                   i_mode_v86,                 // Virtual-8086 mode
    input  wire                   i_system_management_state,  // In system management state
    input  wire                   i_fpu_absent_trap_flag,     // Control reg zero trap flag
    input  wire                   i_task_switched_flag,       // Control reg zero task flag
    input  wire                   i_monitor_coprocessor_flag, // Control reg zero monitor flag
    input  wire                   i_simd_state_save_enable,   // Control reg four save enable
    input  wire                   i_simd_fp_fault_enable,     // Control reg four fault enable
    // Handler invocation feedback from delivery
    input  wire                   i_deliver_exc,              // Exception while invoking a handler
    input  wire [`UDF_VEC_W-1:0]  i_deliver_vec,              // Its vector
    input  wire                   i_deliver_done,             // Handler invocation finished
    // Exception report
    output reg                    o_exc_valid,                // One-cycle report strobe
    output reg  [`UDF_VEC_W-1:0]  o_exc_vector,               // Reported vector
    output reg  [`UDF_CLS_W-1:0]  o_exc_class,                // Reported class
    output reg                    o_err_valid,                // Error code to be pushed
    output reg  [`UDF_ERR_W-1:0]  o_err_code,                 // Error code value
    output reg  [`UDF_IP_W-1:0]   o_saved_ip,                 // Pointer to save
    output reg                    o_suppress,                 // Retiring instruction not executed
    output reg                    o_busy,                     // Handler invocation in progress
    output reg                    o_shutdown                  // Shutdown, stopped until reset
);
    // Invalid-opcode conditions
    wire rsvd_single = i_ins_one_byte &&
                       (i_ins_opcode == `UDF_OPC_RSVD_A || i_ins_opcode == `UDF_OPC_RSVD_B);
    wire c_reserved  = i_ins_reserved && !rsvd_single;
    wire c_operand   = i_ins_bad_operand;

    wire [`UDF_EXT_N-1:0] ext_missing;
    genvar g;
    generate
        for (g = 0; g < `UDF_EXT_N; g = g + 1) begin : g_ext
            assign ext_missing[g] = i_ins_ext_req[g] && !i_feature_id_query[g];
        end
    endgenerate
    wire c_ext       = |ext_missing;

    wire vec_ins     = i_ins_pkint || i_ins_simd;
    wire c_trap      = i_fpu_absent_trap_flag && vec_ins &&
                       !i_ins_trap_exempt && !i_ins_mon_wait;
    wire c_save      = !i_simd_state_save_enable && i_ins_simd &&
                       !i_ins_save_exempt;
    wire c_simd_fp   = i_ins_simd && i_ins_simd_fp_exc &&
                       !i_simd_fp_fault_enable;
    wire c_forced    = i_ins_forced_undef;
    wire c_lock      = i_ins_lock && (!i_ins_lockable || !i_ins_dest_mem);
    wire c_mode      = i_ins_sys_desc && (i_mode_real || i_mode_v86);
    wire c_resume    = i_ins_resume_sysmgmt && !i_system_management_state;

    wire inv_hit = c_reserved || c_operand || c_ext || c_trap || c_save ||
                   c_simd_fp || c_forced || c_lock || c_mode || c_resume;

    // Coprocessor-unavailable conditions
    wire cop_x87  = i_ins_x87 && i_fpu_absent_trap_flag;
    wire cop_sync = i_ins_fpu_sync && i_monitor_coprocessor_flag &&
                    i_task_switched_flag;
    wire cop_task = i_task_switched_flag && !i_fpu_absent_trap_flag &&
                    (i_ins_x87 || vec_ins) && !i_ins_trap_exempt;
    wire cop_hit  = cop_x87 || cop_sync || cop_task;

    // Invalid-opcode takes precedence, then coprocessor, then any other fault
    reg [`UDF_VEC_W-1:0] new_vec;
    reg                  new_hit;
    always @* begin
        new_hit = 1'h1;
        if (inv_hit) begin
            new_vec = `UDF_VEC_INV_OP;
        end else if (cop_hit) begin
            new_vec = `UDF_VEC_COPROC_NA;
        end else if (i_ins_other_exc) begin
            new_vec = i_ins_other_vec;
        end else begin
            new_vec = `UDF_VEC_INV_OP;
            new_hit = 1'h0;
        end
    end

    wire [`UDF_CLS_W-1:0] new_cls;
    wire [`UDF_CLS_W-1:0] dlv_cls;
    udf_classify u_cls_new (
        .i_vector (new_vec),
        .o_class  (new_cls)
    );
    udf_classify u_cls_dlv (
        .i_vector (i_deliver_vec),
        .o_class  (dlv_cls)
    );

    // Handler invocation sequencing
    reg [`UDF_ST_W-1:0]   state_r;
    reg [`UDF_ST_W-1:0]   state_nxt;
    reg [`UDF_CLS_W-1:0]  first_cls_r;
    reg [`UDF_CLS_W-1:0]  first_cls_nxt;
    reg                   rep_valid;
    reg [`UDF_VEC_W-1:0]  rep_vec;
    reg [`UDF_CLS_W-1:0]  rep_cls;
    reg                   rep_err;
    reg                   rep_own;

    // Only a non-serial pair (contributory after contributory, or contributory or page fault after page fault) escalates
    wire dbl_pair = (first_cls_r == `UDF_CLS_CONTRIB && dlv_cls == `UDF_CLS_CONTRIB) ||
                    (first_cls_r == `UDF_CLS_PAGE &&
                     (dlv_cls == `UDF_CLS_CONTRIB || dlv_cls == `UDF_CLS_PAGE));

    always @* begin
        state_nxt     = state_r;
        first_cls_nxt = first_cls_r;
        rep_valid     = 1'h0;
        rep_vec       = new_vec;
        rep_cls       = new_cls;
        rep_err       = 1'h0;
        rep_own       = 1'h0;
        case (state_r)
            `UDF_ST_IDLE: begin
                // Speculative or decoded-only work never reaches here
                if (i_retire_valid && new_hit) begin
                    rep_valid     = 1'h1;
                    rep_own       = 1'h1;
                    first_cls_nxt = new_cls;
                    state_nxt     = `UDF_ST_DELIVER;
                end
            end
            `UDF_ST_DELIVER: begin
                if (i_deliver_exc) begin
                    rep_valid = 1'h1;
                    if (dbl_pair) begin
                        rep_vec   = `UDF_VEC_DBL_FAULT;
                        rep_cls   = `UDF_CLS_BENIGN;
                        rep_err   = 1'h1;
                        state_nxt = `UDF_ST_DBL;
                    end else begin
                        rep_vec       = i_deliver_vec;
                        rep_cls       = dlv_cls;
                        first_cls_nxt = dlv_cls;
                    end
                end else if (i_deliver_done) begin
                    state_nxt = `UDF_ST_IDLE;
                end
            end
            `UDF_ST_DBL: begin
                if (i_deliver_exc) begin
                    state_nxt = `UDF_ST_SHUTDOWN;
                end else if (i_deliver_done) begin
                    state_nxt = `UDF_ST_IDLE;
                end
            end
            `UDF_ST_SHUTDOWN: begin
                // Left only through reset
                state_nxt = `UDF_ST_SHUTDOWN;
            end
            default: begin
                state_nxt = `UDF_ST_IDLE;
            end
        endcase
    end

    always @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_r      <= `UDF_ST_IDLE;
            first_cls_r  <= `UDF_CLS_BENIGN;
            o_exc_valid  <= 1'h0;
            o_exc_vector <= `UDF_VEC_DIVIDE;
            o_exc_class  <= `UDF_CLS_BENIGN;
            o_err_valid  <= 1'h0;
            o_err_code   <= `UDF_ERR_ZERO;
            o_saved_ip   <= {`UDF_IP_W{1'h0}};
            o_suppress   <= 1'h0;
            o_busy       <= 1'h0;
            o_shutdown   <= 1'h0;
        end else begin
            state_r      <= state_nxt;
            first_cls_r  <= first_cls_nxt;
            o_exc_valid  <= rep_valid;
            o_exc_vector <= rep_vec;
            o_exc_class  <= rep_cls;
            // Neither fault here pushes a code; only the double fault does, and it is zero
            o_err_valid  <= rep_valid && rep_err;
            o_err_code   <= `UDF_ERR_ZERO;
            if (rep_own) begin
                o_saved_ip <= i_retire_ip;
            end
            // Faulting instruction is dropped so no program state changes
            o_suppress   <= rep_own;
            o_busy       <= (state_nxt != `UDF_ST_IDLE);
            o_shutdown   <= (state_nxt == `UDF_ST_SHUTDOWN);
        end
    end
endmodule

// ===== udf_detect_checker.sv
// Concurrent port checks for the fault detector
`timescale 1ns/1ps
`include "udf_defines.vh"
module udf_detect_checker (
    input wire        i_ref_clk, i_resetn, i_retire_valid, i_ins_one_byte, i_ins_reserved, i_ins_x87,
    input wire        i_ins_forced_undef, i_ins_sys_desc, i_ins_fpu_sync, i_mode_real, i_mode_v86,
    input wire        i_fpu_absent_trap_flag, i_task_switched_flag, i_monitor_coprocessor_flag,
    input wire        o_exc_valid, o_err_valid, o_suppress, o_busy, o_shutdown,
    input wire [7:0]  i_ins_opcode, o_exc_vector,
    input wire [1:0]  o_exc_class,
    input wire [31:0] i_retire_ip, o_err_code, o_saved_ip
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);
    wire take    = i_retire_valid && !o_busy && !o_shutdown;
    wire rsvd_ok = i_ins_one_byte && (i_ins_opcode == `UDF_OPC_RSVD_A || i_ins_opcode == `UDF_OPC_RSVD_B);
    wire [7:0] v = o_exc_vector;

    property p_undef; take && i_ins_forced_undef |=> o_exc_valid && v == 8'h06 && o_suppress
        && o_saved_ip == $past(i_retire_ip); endproperty
    a_undef: assert property (p_undef) else $error("forced undefined not reported");
    property p_spec; !o_busy && !i_retire_valid |=> !o_exc_valid; endproperty
    a_spec: assert property (p_spec) else $error("report without retirement");
    property p_rsvd; take && i_ins_reserved && !rsvd_ok |=> o_exc_valid && v == 8'h06; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved encoding not reported");
    property p_x87; take && i_ins_x87 && i_fpu_absent_trap_flag |=> o_exc_valid && v inside {8'h06, 8'h07};
    endproperty
    a_x87: assert property (p_x87) else $error("x87 trap not reported");
    property p_sync; take && i_ins_fpu_sync && i_monitor_coprocessor_flag && i_task_switched_flag
        |=> o_exc_valid && v inside {8'h06, 8'h07}; endproperty
    a_sync: assert property (p_sync) else $error("sync trap not reported");
    property p_sysd; take && i_ins_sys_desc && (i_mode_real || i_mode_v86) |=> o_exc_valid && v == 8'h06;
    endproperty
    a_sysd: assert property (p_sysd) else $error("descriptor op not reported");
    property p_cls; o_exc_valid && v != 8'h08 |-> o_exc_class == ((v == 8'h00 || (v >= 8'h0a && v <= 8'h0d))
        ? 2'h1 : (v == 8'h0e) ? 2'h2 : 2'h0); endproperty
    a_cls: assert property (p_cls) else $error("wrong class code");
    property p_dbl; o_exc_valid && v == 8'h08 |-> o_err_valid && o_err_code == 32'h0; endproperty
    a_dbl: assert property (p_dbl) else $error("double fault error code wrong");
    property p_noerr; o_err_valid |-> o_exc_valid && v == 8'h08; endproperty
    a_noerr: assert property (p_noerr) else $error("error code on plain fault");
    property p_shut; o_shutdown |=> o_shutdown && !o_exc_valid; endproperty
    a_shut: assert property (p_shut) else $error("shutdown left or reported");
endmodule

bind udf_detect udf_detect_checker chk (.*);

// ===== udf_pipe_model.sv
// Pipeline model that finishes each handler invocation after a set delay
`timescale 1ns/1ps
module udf_pipe_model (
    input  wire       i_ref_clk, // Core clock
    input  wire       i_resetn,  // Async reset, active low
    input  wire       i_busy,    // Invocation in progress
    input  wire       i_hold,    // Stall, never finish
    input  wire [3:0] i_delay,   // Extra cycles before finishing
    output reg        o_done     // Invocation finished pulse
);
    reg [3:0] cnt_r;
    always @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cnt_r  <= 4'h0;
            o_done <= 1'h0;
        end else begin
            o_done <= 1'h0;
            cnt_r  <= 4'h0;
            // Skip the cycle after done so one invocation never gets two pulses
            if (i_busy && !o_done && !i_hold) begin
                if (cnt_r == i_delay) o_done <= 1'h1;
                else cnt_r <= cnt_r + 4'h1;
            end
        end
    end
endmodule

// ===== test_undefined_op_and_fpu_fault_detect.sv
// Self-checking bench for the invalid-opcode and coprocessor fault detector
`timescale 1ns/1ps
module test_undefined_op_and_fpu_fault_detect;
    reg         i_ref_clk, i_resetn, i_retire_valid, i_ins_one_byte, i_ins_reserved, i_ins_bad_operand, i_ins_x87;
    reg         i_ins_pkint, i_ins_simd, i_ins_trap_exempt, i_ins_mon_wait, i_ins_save_exempt, i_ins_simd_fp_exc;
    reg         i_ins_forced_undef, i_ins_lock, i_ins_lockable, i_ins_dest_mem, i_ins_sys_desc, i_ins_resume_sysmgmt;
    reg         i_ins_fpu_sync, i_ins_other_exc, i_mode_real, i_mode_v86, i_system_management_state, hold;
    reg         i_fpu_absent_trap_flag, i_task_switched_flag, i_monitor_coprocessor_flag, i_deliver_exc;
    reg         i_simd_state_save_enable, i_simd_fp_fault_enable;
    reg  [4:0]  i_ins_ext_req, i_feature_id_query;
    reg  [7:0]  i_ins_opcode, i_ins_other_vec, i_deliver_vec, v;
    reg  [31:0] i_retire_ip, ip;
    reg  [3:0]  dly;
    wire        i_deliver_done, o_exc_valid, o_err_valid, o_suppress, o_busy, o_shutdown;
    wire [7:0]  o_exc_vector;
    wire [1:0]  o_exc_class;
    wire [31:0] o_err_code, o_saved_ip;
    integer     mismatches, comparisons;

    udf_detect dut (.*);
    udf_pipe_model pm (.i_ref_clk, .i_resetn, .i_busy(o_busy), .i_hold(hold), .i_delay(dly), .o_done(i_deliver_done));

    initial begin
        i_ref_clk = 1'h0;
        forever #50 i_ref_clk = ~i_ref_clk;
    end

    task ck(input [31:0] a, input [31:0] e); begin
        comparisons = comparisons + 1;
        if (a !== e) begin
            mismatches = mismatches + 1;
            $display("mismatch at %0t: got %h expected %h", $time, a, e);
        end
    end endtask

    task conclude; begin
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    end endtask

    // Idle instruction: nothing flagged, all extensions advertised, SIMD enabled
    task clr; begin
        {i_ins_one_byte, i_ins_reserved, i_ins_bad_operand, i_ins_x87, i_ins_pkint, i_ins_simd, i_ins_trap_exempt,
         i_ins_mon_wait, i_ins_save_exempt, i_ins_simd_fp_exc, i_ins_forced_undef, i_ins_lock, i_ins_lockable,
         i_ins_dest_mem, i_ins_sys_desc, i_ins_resume_sysmgmt, i_ins_fpu_sync, i_ins_other_exc, i_mode_real,
         i_mode_v86, i_system_management_state, i_fpu_absent_trap_flag, i_task_switched_flag,
         i_monitor_coprocessor_flag, i_deliver_exc, i_ins_ext_req, i_ins_opcode, i_ins_other_vec} <= '0;
        i_simd_state_save_enable <= 1'h1;
        i_simd_fp_fault_enable <= 1'h1;
        i_feature_id_query <= 5'h1f;
    end endtask

    task rst; begin
        i_resetn <= 1'h0;
        hold <= 1'h0;
        repeat (3) @(posedge i_ref_clk);
        i_resetn <= 1'h1;
    end endtask

    // Retire one instruction once idle; e of ff means no report expected
    task go(input [7:0] e); integer n; begin
        n = 0;
        #1;
        while (o_busy !== 1'h0 && n < 40) begin
            @(posedge i_ref_clk);
            #1;
            n = n + 1;
        end
        if (o_busy !== 1'h0) begin
            mismatches = mismatches + 1;
            conclude;
        end
        @(posedge i_ref_clk);
        ip = ip + 32'h10;
        i_retire_valid <= 1'h1;
        i_retire_ip <= ip;
        @(posedge i_ref_clk);
        i_retire_valid <= 1'h0;
        clr;
        #1;
        ck(o_exc_valid, e != 8'hff);
        ck(o_busy, e != 8'hff);
        if (e != 8'hff) begin
            ck(o_exc_vector, e);
            ck(o_exc_class, (e == 8'h00 || (e >= 8'h0a && e <= 8'h0d)) ? 2'h1 : (e == 8'h0e) ? 2'h2 : 2'h0);
            ck(o_saved_ip, ip);
            ck(o_suppress, 1'h1);
            ck(o_err_valid, 1'h0);
        end
    end endtask

    task dx(input [7:0] e); begin
        @(posedge i_ref_clk);
        i_deliver_exc <= 1'h1;
        i_deliver_vec <= e;
        @(posedge i_ref_clk);
        i_deliver_exc <= 1'h0;
        #1;
    end endtask

    initial begin
        mismatches = 0;
        comparisons = 0;
        ip = 32'h1000;
        dly = 4'h0;
        i_retire_valid <= 1'h0;
        i_retire_ip <= 32'h0;
        i_deliver_vec <= 8'h0;
        clr;
        rst;
        i_ins_reserved <= 1'h1;
        repeat (2) @(posedge i_ref_clk);
        #1 ck(o_exc_valid, 1'h0);
        go(8'h06);
        i_ins_reserved <= 1'h1; i_ins_one_byte <= 1'h1; i_ins_opcode <= 8'hd6; go(8'hff);
        i_ins_reserved <= 1'h1; i_ins_one_byte <= 1'h1; i_ins_opcode <= 8'hf1; go(8'hff);
        i_ins_reserved <= 1'h1; i_ins_opcode <= 8'hd6; go(8'h06);
        i_ins_bad_operand <= 1'h1; go(8'h06);
        i_ins_ext_req <= 5'h04; i_feature_id_query <= 5'h1b; go(8'h06);
        i_ins_ext_req <= 5'h04; go(8'hff);
        i_ins_pkint <= 1'h1; i_fpu_absent_trap_flag <= 1'h1; go(8'h06);
        i_ins_simd <= 1'h1; i_ins_trap_exempt <= 1'h1; i_fpu_absent_trap_flag <= 1'h1; go(8'hff);
        i_ins_simd <= 1'h1; i_ins_mon_wait <= 1'h1; i_fpu_absent_trap_flag <= 1'h1; go(8'hff);
        i_ins_simd <= 1'h1; i_simd_state_save_enable <= 1'h0; go(8'h06);
        i_ins_simd <= 1'h1; i_ins_save_exempt <= 1'h1; i_simd_state_save_enable <= 1'h0; go(8'hff);
        i_ins_simd <= 1'h1; i_ins_simd_fp_exc <= 1'h1; i_simd_fp_fault_enable <= 1'h0; go(8'h06);
        i_ins_forced_undef <= 1'h1; go(8'h06);
        i_ins_lock <= 1'h1; go(8'h06);
        i_ins_lock <= 1'h1; i_ins_lockable <= 1'h1; go(8'h06);
        i_ins_lock <= 1'h1; i_ins_lockable <= 1'h1; i_ins_dest_mem <= 1'h1; go(8'hff);
        i_ins_sys_desc <= 1'h1; i_mode_real <= 1'h1; go(8'h06);
        i_ins_sys_desc <= 1'h1; i_mode_v86 <= 1'h1; go(8'h06);
        i_ins_sys_desc <= 1'h1; go(8'hff);
        i_ins_resume_sysmgmt <= 1'h1; go(8'h06);
        i_ins_resume_sysmgmt <= 1'h1; i_system_management_state <= 1'h1; go(8'hff);
        $display("test decode done");
        i_ins_x87 <= 1'h1; i_fpu_absent_trap_flag <= 1'h1; go(8'h07);
        i_ins_fpu_sync <= 1'h1; i_monitor_coprocessor_flag <= 1'h1; i_task_switched_flag <= 1'h1;
        i_fpu_absent_trap_flag <= 1'h1; go(8'h07);
        i_ins_x87 <= 1'h1; i_task_switched_flag <= 1'h1; go(8'h07);
        i_ins_pkint <= 1'h1; i_task_switched_flag <= 1'h1; go(8'h07);
        i_ins_simd <= 1'h1; i_ins_mon_wait <= 1'h1; i_task_switched_flag <= 1'h1; go(8'h07);
        i_ins_simd <= 1'h1; i_ins_trap_exempt <= 1'h1; i_task_switched_flag <= 1'h1; go(8'hff);
        i_ins_x87 <= 1'h1; i_ins_bad_operand <= 1'h1; i_fpu_absent_trap_flag <= 1'h1; go(8'h06);
        $display("test coprocessor done");
        for (v = 8'h00; v < 8'h14; v = v + 8'h01) begin
            dly <= v[0] ? 4'h5 : 4'h0;
            if (v != 8'h08) begin
                i_ins_other_exc <= 1'h1; i_ins_other_vec <= v; go(v);
            end
        end
        $display("test classes done");
        // Drain the last invocation before stalling the pipeline model
        go(8'hff);
        i_ins_other_exc <= 1'h1; i_ins_other_vec <= 8'h0d; hold <= 1'h1; go(8'h0d);
        dx(8'h0e); ck(o_exc_vector, 8'h0e); ck(o_exc_class, 2'h2); ck(o_err_valid, 1'h0);
        dx(8'h0d); ck(o_exc_valid, 1'h1); ck(o_exc_vector, 8'h08); ck(o_err_valid, 1'h1);
        ck(o_err_code, 32'h0);
        dx(8'h01); ck(o_exc_valid, 1'h0); ck(o_shutdown, 1'h1);
        rst;
        i_ins_other_exc <= 1'h1; i_ins_other_vec <= 8'h0e; hold <= 1'h1; go(8'h0e);
        dx(8'h03); ck(o_exc_vector, 8'h03);
        dx(8'h0d); ck(o_exc_vector, 8'h0d); ck(o_err_valid, 1'h0); ck(o_shutdown, 1'h0);
        dx(8'h0c); ck(o_exc_vector, 8'h08); ck(o_err_valid, 1'h1);
        $display("test double fault done");
        conclude;
    end
endmodule
